// ### fcr_consts.svh
// constants for the flash configuration register command block
`ifndef FCR_CONSTS_SVH
`define FCR_CONSTS_SVH

// opcodes
`define FCR_OP_WRITE_ENABLE     8'h06
`define FCR_OP_WRITE_DISABLE    8'h04
`define FCR_OP_READ_STATUS_LO   8'h05
`define FCR_OP_READ_STATUS_HI   8'h35
`define FCR_OP_READ_CONFIG      8'h15
`define FCR_OP_WRITE_STATUS     8'h01
`define FCR_OP_WRITE_CONFIG     8'h11
`define FCR_OP_READ_EXT         8'hc8
`define FCR_OP_WRITE_EXT        8'h56

// frame lengths in serial clocks
`define FCR_BITS_OPCODE         6'h08
`define FCR_BITS_ONE_BYTE       6'h10
`define FCR_BITS_TWO_BYTES      6'h18
`define FCR_BITS_MAX            6'h3f

// configuration register fields
`define FCR_CFG_PIN_RESET_BIT   7
`define FCR_CFG_DRV_HI_BIT      6
`define FCR_CFG_DRV_LO_BIT      5
`define FCR_CFG_PAGE_HI_BIT     4
`define FCR_CFG_PAGE_LO_BIT     3
`define FCR_CFG_WPS_BIT         2
`define FCR_CFG_WRITE_MASK      8'hfc
`define FCR_CFG_RESET           8'h00

// status register fields
`define FCR_ST_SUS1_BIT         15
`define FCR_ST_SUS2_BIT         10
`define FCR_ST_QE_BIT           9
`define FCR_ST_STATUS_PROTECT_HI_BIT         8
`define FCR_ST_STATUS_PROTECT_LO_BIT         7
`define FCR_ST_WEL_BIT          1
`define FCR_ST_WIP_BIT          0
`define FCR_ST_WRITE_MASK       16'h7bfc
`define FCR_ST_SHORT_CLEAR      16'h4300
`define FCR_ST_LB_MASK          16'h3800
`define FCR_ST_RESET            16'h0000

// extended control register fields
`define FCR_EXT_DUMMY_BIT       7
`define FCR_EXT_LEARN_BIT       3
`define FCR_EXT_WRITE_MASK      8'h88
`define FCR_EXT_RESET           8'h00

// read timing controls
`define FCR_DUMMY_2IO_SHORT     4'h4
`define FCR_DUMMY_2IO_LONG      4'h8
`define FCR_DUMMY_4IO_SHORT     4'h6
`define FCR_DUMMY_4IO_LONG      4'ha
`define FCR_LEARN_PATTERN       8'h34

// page sizes in bytes
`define FCR_PAGE_256            11'h100
`define FCR_PAGE_512            11'h200
`define FCR_PAGE_1024           11'h400

// self-timed write cycle
`define FCR_WRITE_TIME_US       5000
`define FCR_MCLK_PERIOD_NS      50
`define FCR_WRITE_CYCLES ((`FCR_WRITE_TIME_US * 1000) / `FCR_MCLK_PERIOD_NS)

`endif

// ### fcr_pkg.sv
// types for the flash configuration register command block
package fcr_pkg;

    typedef enum logic [1:0] {
        FCR_DRIVE_100,
        FCR_DRIVE_150,
        FCR_DRIVE_200,
        FCR_DRIVE_50
    } fcr_drive_type;

    typedef enum logic [1:0] {
        FCR_PAGE_MODE_256,
        FCR_PAGE_MODE_512,
        FCR_PAGE_MODE_1024,
        FCR_PAGE_MODE_RSVD
    } fcr_page_mode_type;

    typedef enum {
        FCR_IDLE,
        FCR_BUSY
    } fcr_state_type;

    // what the link side has seen of one frame
    typedef struct packed {
        logic [5:0]  bits;
        logic [23:0] shift;
    } fcr_frame_type;

    // controls that feed the array, pin and read logic
    typedef struct packed {
        logic                      pin_is_hold;
        logic                      pin_is_reset;
        fcr_drive_type             drive;
        logic [10:0]               page_bytes;
        logic                      erase_dual_page;
        logic                      erase_quad_page;
        logic                      block_lock_scheme;
        logic [3:0]                dummy_2io;
        logic [3:0]                dummy_4io;
        logic                      learn_enable;
        logic [7:0]                learn_pattern;
    } fcr_view_type;

endpackage

// ### fcr_top.sv
// register command handling of the serial flash: link and core domains
//
// Notes on behaviour
// - read-config shifts config byte out, even when busy.
// - config bit 7 picks hold or reset pin while quad enable 0.
// - drive field: 100, 150, 200, 50 percent strength.
// - page-mode field: 256, 512, 1024 byte pages; 11 reserved.
// - page buffer load address wraps at selected page size.
// - page erase covers dual page at mode 01, quad page at mode 10.
// - scheme bit picks range protection or individual block locks.
// - every block lock bit reads locked after any reset.
// - status write taken only with write enable latch set.
// - status write leaves bits 15, 10, 1 and 0 alone.
// - status write ends exactly after 8 or 16 data bits, else dropped.
// - eight-bit status write clears complement, quad enable, upper protect.
// - valid status write runs timed cycle, then latch clears.
// - status write refused while hardware protected.
// - config write needs latch set and exactly eight data bits.
// - accepted config write runs timed cycle, then latch clears.
// - extended register read shifts out on falling clock, msb first.
// - extended register: dummy bit at 7, learning enable at 3.
// - dummy bit sets 2-io dummies 4 or 8, 4-io 6 or 10.
// - learning enable drives fixed pattern in read dummy cycles.
// - learning enable changes only by extended register write.
// - with latch clear, every register write is ignored.
// - extended register clears to zero on every reset.
// - lower protect 1, upper 0, protect pin low locks status.
`include "fcr_consts.svh"

module fcr_top #(
    parameter int unsigned WRITE_CYCLES = `FCR_WRITE_CYCLES,
    parameter int unsigned NUM_LOCKS    = 16
) (
    // core clock and reset
    input  wire logic             mclk,
    input  wire logic             resetn,
    // serial link
    input  wire logic             sclk,
    input  wire logic             cs_n,
    input  wire logic             si,
    output logic                  so,
    output logic                  so_oe_n,
    // pins and suspend state
    input  wire logic             write_protect_n,
    input  wire logic             erase_suspended,
    input  wire logic             program_suspended,
    // page buffer loading
    input  wire logic             buf_start,
    input  wire logic [9:0]       buf_start_offset,
    input  wire logic             buf_load,
    output logic [9:0]            buf_addr_q,
    // controls to the rest of the device
    output fcr_pkg::fcr_view_type view_q,
    output logic [NUM_LOCKS-1:0]  block_locks_q,
    output logic [15:0]           status_word,
    output logic                  write_in_progress,
    output logic                  write_enable_latch
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [9:0] wrap_next(
        input logic [9:0] addr,
        input logic [1:0] mode
    );
        logic [9:0] nxt;
        nxt = addr;
        case (mode)
            2'h1:    nxt = {addr[9], addr[8:0] + 9'h001};
            2'h2:    nxt = addr + 10'h001;
            default: nxt = {addr[9:8], addr[7:0] + 8'h01};
        endcase
        return nxt;
    endfunction

    function automatic logic [7:0] pick_read(
        input logic [7:0]  op,
        input logic [31:0] regs
    );
        logic [7:0] b;
        b = 8'h00;
        case (op)
            `FCR_OP_READ_STATUS_LO: b = regs[7:0];
            `FCR_OP_READ_STATUS_HI: b = regs[15:8];
            `FCR_OP_READ_CONFIG:    b = regs[23:16];
            `FCR_OP_READ_EXT:       b = regs[31:24];
            default:                b = 8'h00;
        endcase
        return b;
    endfunction

    function automatic logic is_read(input logic [7:0] op);
        return (op == `FCR_OP_READ_STATUS_LO) ||
               (op == `FCR_OP_READ_STATUS_HI) ||
               (op == `FCR_OP_READ_CONFIG) ||
               (op == `FCR_OP_READ_EXT);
    endfunction

    // ************************************************************
    // core register state
    // ************************************************************
    fcr_pkg::fcr_state_type state_q;
    logic [31:0]            timer_q;
    logic [15:0]            status_q;
    logic [15:0]            status_pend_q;
    logic [7:0]             config_q;
    logic [7:0]             config_pend_q;
    logic                   pend_is_config_q;
    logic [7:0]             ext_q;
    logic                   wel_q;
    logic                   busy;

    assign busy = (state_q == fcr_pkg::FCR_BUSY);

    always_comb begin
        status_word = status_q & `FCR_ST_WRITE_MASK;
        status_word[`FCR_ST_SUS1_BIT] = erase_suspended;
        status_word[`FCR_ST_SUS2_BIT] = program_suspended;
        status_word[`FCR_ST_WEL_BIT] = wel_q;
        status_word[`FCR_ST_WIP_BIT] = busy;
    end

    assign write_in_progress  = busy;
    assign write_enable_latch = wel_q;

    // ************************************************************
    // link domain: shift in on rising clock
    // ************************************************************
    logic        first_q;
    logic [5:0]  bits_q;
    logic [23:0] shift_q;

    // cs high arms a fresh count; sclk may stop meanwhile
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            first_q <= 1'b1;
        end else begin
            first_q <= 1'b0;
        end
    end

    // opcode and data enter on rising edges
    always_ff @(posedge sclk) begin
        if (first_q) begin
            bits_q <= 6'h01;
        end else if (bits_q != `FCR_BITS_MAX) begin
            bits_q <= bits_q + 6'h01;
        end
        shift_q <= {shift_q[22:0], si};
    end

    // register values brought onto the link clock
    logic [31:0] regs_core;
    logic [31:0] regs_s1_q;
    logic [31:0] regs_s2_q;

    assign regs_core = {ext_q & `FCR_EXT_WRITE_MASK,
                        config_q & `FCR_CFG_WRITE_MASK,
                        status_word};

    // values change only at frame ends, write cycle ends or with the suspend inputs, so tearing is limited
    always_ff @(posedge sclk) begin
        regs_s1_q <= regs_core;
        regs_s2_q <= regs_s1_q;
    end

    // ************************************************************
    // link domain: shift out on falling clock
    // ************************************************************
    logic [7:0] out_q;
    logic [7:0] rd_byte;
    logic       so_q;
    logic       oe_n_q;

    assign rd_byte = pick_read(shift_q[7:0], regs_s2_q);

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            so_q   <= 1'b0;
            oe_n_q <= 1'b1;
            out_q  <= 8'h00;
        end else if (bits_q == `FCR_BITS_OPCODE && !first_q &&
                     is_read(shift_q[7:0])) begin
            // reads are served even during a write cycle
            so_q   <= rd_byte[7];
            out_q  <= {rd_byte[6:0], rd_byte[7]};
            oe_n_q <= 1'b0;
        end else if (!oe_n_q) begin
            // msb first, byte repeats while cs stays low
            so_q  <= out_q[7];
            out_q <= {out_q[6:0], out_q[7]};
        end
    end

    assign so      = so_q;
    assign so_oe_n = oe_n_q;

    // ************************************************************
    // core domain: frame end and pin synchronisers
    // ************************************************************
    logic                  cs_s1_q;
    logic                  cs_s2_q;
    logic                  cs_s3_q;
    logic                  wp_s1_q;
    logic                  wp_s2_q;
    logic                  frame_end;
    fcr_pkg::fcr_frame_type frame;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
            wp_s1_q <= 1'b1;
            wp_s2_q <= 1'b1;
        end else begin
            cs_s1_q <= cs_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
            wp_s1_q <= write_protect_n;
            wp_s2_q <= wp_s1_q;
        end
    end

    // link registers hold once cs is high; the synced edge
    // is the handshake for the frame word
    assign frame_end   = cs_s2_q && !cs_s3_q;
    assign frame.bits  = bits_q;
    assign frame.shift = shift_q;

    logic [7:0] op_one;
    logic [7:0] op_two;
    logic [7:0] data_one;
    logic       hw_protect;
    logic       wr_ok;

    assign op_one   = frame.shift[15:8];
    assign op_two   = frame.shift[23:16];
    assign data_one = frame.shift[7:0];

    // locked by protect pin, or by lock-down of the upper bit
    assign hw_protect = status_q[`FCR_ST_STATUS_PROTECT_HI_BIT] ||
                        (status_q[`FCR_ST_STATUS_PROTECT_LO_BIT] && !wp_s2_q);

    // no register write without the latch, none while busy
    assign wr_ok = frame_end && wel_q && !busy;

    // ************************************************************
    // core domain: command execution and write cycle
    // ************************************************************
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q          <= fcr_pkg::FCR_IDLE;
            timer_q          <= 32'h0;
            status_pend_q    <= `FCR_ST_RESET;
            config_pend_q    <= `FCR_CFG_RESET;
            pend_is_config_q <= 1'b0;
        end else if (state_q == fcr_pkg::FCR_IDLE) begin
            if (wr_ok && op_one == `FCR_OP_WRITE_STATUS &&
                frame.bits == `FCR_BITS_ONE_BYTE && !hw_protect) begin
                // short write clears cmp, qe and upper protect
                status_pend_q <= ((status_q & 16'hff00) |
                                  {8'h00, data_one}) &
                                 ~`FCR_ST_SHORT_CLEAR;
                pend_is_config_q <= 1'b0;
                timer_q <= WRITE_CYCLES[31:0];
                state_q <= fcr_pkg::FCR_BUSY;
            end else if (wr_ok && op_two == `FCR_OP_WRITE_STATUS &&
                         frame.bits == `FCR_BITS_TWO_BYTES &&
                         !hw_protect) begin
                // low byte first, then high byte
                status_pend_q <= {data_one, op_one} |
                                 (status_q & `FCR_ST_LB_MASK);
                pend_is_config_q <= 1'b0;
                timer_q <= WRITE_CYCLES[31:0];
                state_q <= fcr_pkg::FCR_BUSY;
            end else if (wr_ok && op_one == `FCR_OP_WRITE_CONFIG &&
                         frame.bits == `FCR_BITS_ONE_BYTE) begin
                config_pend_q    <= data_one;
                pend_is_config_q <= 1'b1;
                timer_q <= WRITE_CYCLES[31:0];
                state_q <= fcr_pkg::FCR_BUSY;
            end
        end else begin
            if (timer_q <= 32'h1) begin
                state_q <= fcr_pkg::FCR_IDLE;
                timer_q <= 32'h0;
            end else begin
                timer_q <= timer_q - 32'h1;
            end
        end
    end

    // committed values appear only when the cycle ends
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            status_q <= `FCR_ST_RESET;
            config_q <= `FCR_CFG_RESET;
        end else if (busy && timer_q <= 32'h1) begin
            if (pend_is_config_q) begin
                config_q <= config_pend_q & `FCR_CFG_WRITE_MASK;
            end else begin
                // suspend, latch and busy bits are never stored
                status_q <= status_pend_q & `FCR_ST_WRITE_MASK;
            end
        end
    end

    // write enable latch
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            wel_q <= 1'b0;
        end else if (busy && timer_q <= 32'h1) begin
            wel_q <= 1'b0;
        end else if (frame_end && !busy &&
                     frame.bits == `FCR_BITS_OPCODE &&
                     data_one == `FCR_OP_WRITE_ENABLE) begin
            wel_q <= 1'b1;
        end else if (frame_end && !busy &&
                     frame.bits == `FCR_BITS_OPCODE &&
                     data_one == `FCR_OP_WRITE_DISABLE) begin
            wel_q <= 1'b0;
        end else if (wr_ok && op_one == `FCR_OP_WRITE_EXT &&
                     frame.bits == `FCR_BITS_ONE_BYTE) begin
            wel_q <= 1'b0;
        end
    end

    // volatile extended register, only its own write command
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ext_q <= `FCR_EXT_RESET;
        end else if (wr_ok && op_one == `FCR_OP_WRITE_EXT &&
                     frame.bits == `FCR_BITS_ONE_BYTE) begin
            ext_q <= data_one & `FCR_EXT_WRITE_MASK;
        end
    end

    // ************************************************************
    // core domain: controls to the rest of the device
    // ************************************************************
    logic [1:0] page_mode;

    assign page_mode = config_q[`FCR_CFG_PAGE_HI_BIT:`FCR_CFG_PAGE_LO_BIT];

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            view_q <= '0;
        end else begin
            // pin function only when quad enable is off
            view_q.pin_is_hold  <= !status_q[`FCR_ST_QE_BIT] &&
                                   !config_q[`FCR_CFG_PIN_RESET_BIT];
            view_q.pin_is_reset <= !status_q[`FCR_ST_QE_BIT] &&
                                   config_q[`FCR_CFG_PIN_RESET_BIT];
            view_q.drive <= fcr_pkg::fcr_drive_type'(
                config_q[`FCR_CFG_DRV_HI_BIT:`FCR_CFG_DRV_LO_BIT]);
            case (page_mode)
                2'h1:    view_q.page_bytes <= `FCR_PAGE_512;
                2'h2:    view_q.page_bytes <= `FCR_PAGE_1024;
                default: view_q.page_bytes <= `FCR_PAGE_256;
            endcase
            view_q.erase_dual_page <= (page_mode == 2'h1);
            view_q.erase_quad_page <= (page_mode == 2'h2);
            view_q.block_lock_scheme <= config_q[`FCR_CFG_WPS_BIT];
            view_q.dummy_2io <= ext_q[`FCR_EXT_DUMMY_BIT] ?
                `FCR_DUMMY_2IO_LONG : `FCR_DUMMY_2IO_SHORT;
            view_q.dummy_4io <= ext_q[`FCR_EXT_DUMMY_BIT] ?
                `FCR_DUMMY_4IO_LONG : `FCR_DUMMY_4IO_SHORT;
            view_q.learn_enable <= ext_q[`FCR_EXT_LEARN_BIT];
            view_q.learn_pattern <= ext_q[`FCR_EXT_LEARN_BIT] ?
                `FCR_LEARN_PATTERN : 8'h00;
        end
    end

    // lock bits come up locked; the lock commands live elsewhere
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            block_locks_q <= '1;
        end else begin
            block_locks_q <= block_locks_q;
        end
    end

    // page buffer load address
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            buf_addr_q <= 10'h000;
        end else if (buf_start) begin
            buf_addr_q <= buf_start_offset;
        end else if (buf_load) begin
            buf_addr_q <= wrap_next(buf_addr_q, page_mode);
        end
    end

endmodule

// ### fcr_host_model.sv
// host serial controller model facing the link side of the block
module fcr_host_model (
    // serial link
    output logic      sclk,
    output logic      cs_n,
    output logic      si,
    input  wire logic so
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        si   = 1'b1;
        #5 cs_n = 1'b1;
    end

    // ********************
    // one frame, msb first; rx is the first answer byte
    // ********************
    task automatic xfer(input int nbits, input logic [23:0] tx,
                        output logic [7:0] rx);
        rx   = 8'h00;
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si = tx[23-i];
            #6 sclk = 1'b1;
            if (i >= 8 && i < 16)
                rx = {rx[6:0], so};
            #6 sclk = 1'b0;
        end
        cs_n = 1'b1;
        // a released line must not look like the last bit
        si = ~si;
        #300;
    endtask
endmodule

// ### fcr_top_props.sv
// port assertions for the register command block
module fcr_top_props #(
    parameter int unsigned WRITE_CYCLES = 20,
    parameter int unsigned NUM_LOCKS    = 16
) (
    // core clock and reset
    input wire logic                  mclk,
    input wire logic                  resetn,
    // link and suspend state
    input wire logic                  cs_n,
    input wire logic                  so,
    input wire logic                  so_oe_n,
    input wire logic                  erase_suspended,
    input wire logic                  program_suspended,
    // page buffer
    input wire logic                  buf_start,
    input wire logic                  buf_load,
    input wire logic [9:0]            buf_addr_q,
    // controls
    input wire fcr_pkg::fcr_view_type view_q,
    input wire logic [NUM_LOCKS-1:0]  block_locks_q,
    input wire logic [15:0]           status_word,
    input wire logic                  write_in_progress,
    input wire logic                  write_enable_latch
);
    logic [31:0] busy_cnt_q;
    logic [9:0]  wrap_mask;

    default clocking dc @(posedge mclk); endclocking
    default disable iff (!resetn);

    assign wrap_mask = 10'(view_q.page_bytes - 11'h1);

    // too long for a repetition, so count it
    always_ff @(posedge mclk) begin
        if (!resetn || !write_in_progress)
            busy_cnt_q <= '0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    // ********************
    // assertions
    // ********************
    a_cycle_length: assert property (
        $fell(write_in_progress) |-> busy_cnt_q == WRITE_CYCLES)
        else $error("cycle length");
    a_latch_done: assert property (
        $fell(write_in_progress) |-> !write_enable_latch)
        else $error("latch kept");
    a_start_latch: assert property (
        $rose(write_in_progress) |-> write_enable_latch)
        else $error("cycle without latch");
    a_flags_shown: assert property (
        status_word[15] == erase_suspended &&
        status_word[10] == program_suspended &&
        status_word[1:0] == {write_enable_latch, write_in_progress})
        else $error("fixed bits");
    a_locks_set: assert property (&block_locks_q)
        else $error("lock clear");
    a_pin_qe: assert property (
        $past(resetn) |-> !(view_q.pin_is_hold && view_q.pin_is_reset) &&
        (view_q.pin_is_hold || view_q.pin_is_reset) == !$past(status_word[9]))
        else $error("pin function");
    a_learn_pattern: assert property (
        view_q.learn_pattern == (view_q.learn_enable ? 8'h34 : 8'h00))
        else $error("learn pattern");
    a_dummy_pair: assert property (
        $past(resetn) |-> {view_q.dummy_2io, view_q.dummy_4io}
        inside {8'h46, 8'h8a})
        else $error("dummy counts");
    a_buf_wrap: assert property (
        buf_load && !buf_start |=> buf_addr_q ==
        (($past(buf_addr_q) & ~$past(wrap_mask)) |
        (($past(buf_addr_q) + 10'h1) & $past(wrap_mask))))
        else $error("buffer wrap");
    a_quiet_link: assert property (
        cs_n && $past(cs_n) |-> so_oe_n && !so)
        else $error("so while idle");
endmodule

bind fcr_top fcr_top_props #(.WRITE_CYCLES(WRITE_CYCLES),
    .NUM_LOCKS(NUM_LOCKS)) props_u (.mclk, .resetn, .cs_n, .so, .so_oe_n,
    .erase_suspended, .program_suspended, .buf_start, .buf_load,
    .buf_addr_q, .view_q, .block_locks_q, .status_word,
    .write_in_progress, .write_enable_latch);

// ### fcr_top_bench.sv
// self-checking bench of the register command block
`define CHK(what, exp, got) \
    if ((got) !== (exp)) begin \
        $display("BAD %s exp %h got %h", what, exp, got); \
        err_count++; \
    end \
    checks_done++;
module fcr_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned CYC = 20;
    localparam logic [7:0] CFGS [4] = '{8'he8, 8'h54, 8'h2c, 8'h00};
    logic                  mclk = 1'b0;
    logic                  resetn = 1'b0;
    logic                  sclk, cs_n, si, so, so_oe_n;
    logic                  write_protect_n = 1'b1;
    logic                  erase_suspended = 1'b0;
    logic                  program_suspended = 1'b0;
    logic                  buf_start = 1'b0;
    logic                  buf_load = 1'b0;
    logic [9:0]            buf_start_offset = 10'h2ff;
    logic [9:0]            buf_addr_q;
    fcr_pkg::fcr_view_type view_q;
    logic [15:0]           block_locks_q, status_word;
    logic                  write_in_progress, write_enable_latch;
    logic [7:0]            rx;
    int                    err_count = 0;
    int                    checks_done = 0;
    int                    cycles = 0;

    fcr_top #(.WRITE_CYCLES(CYC)) dut_u (.mclk, .resetn, .sclk, .cs_n, .si,
        .so, .so_oe_n, .write_protect_n, .erase_suspended, .program_suspended,
        .buf_start, .buf_start_offset, .buf_load, .buf_addr_q, .view_q,
        .block_locks_q, .status_word, .write_in_progress, .write_enable_latch);
    fcr_host_model hp_u (.sclk, .cs_n, .si, .so);

    initial forever #25 mclk = ~mclk;

    // ********************
    // shared tasks
    // ********************
    task automatic finish_test();
        if (err_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        tick(2);
        resetn = 1'b1;
        tick(3);
    endtask
    task automatic cmd(int n, logic [23:0] tx);
        hp_u.xfer(n, tx, rx);
        tick(1);
    endtask
    task automatic write_enable_cmd();
        cmd(8, 24'h060000);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 100 && write_in_progress !== 1'b0; i++)
            tick(1);
        `CHK("idle", 1'b0, write_in_progress)
    endtask

    // ********************
    // scenarios
    // ********************
    task automatic s_reset_values();
        cmd(16, 24'h150000);
        `CHK("config", 8'h00, rx)
        cmd(16, 24'hc80000);
        `CHK("ext", 8'h00, rx)
        `CHK("locks", {16{1'b1}}, block_locks_q)
        `CHK("dummy", 8'h46, {view_q.dummy_2io, view_q.dummy_4io})
    endtask
    task automatic s_latch_gate();
        write_enable_cmd();
        `CHK("wel", 1'b1, write_enable_latch)
        cmd(8, 24'h040000);
        cmd(16, 24'h11ff00);
        `CHK("no cycle", 1'b0, write_in_progress)
        cmd(16, 24'h150000);
        `CHK("config kept", 8'h00, rx)
    endtask
    task automatic s_config();
        logic [9:0] m;
        for (int k = 0; k < 4; k++) begin
            write_enable_cmd();
            cmd(16, {8'h11, CFGS[k], 8'h00});
            `CHK("busy", 1'b1, write_in_progress)
            cmd(16, 24'h150000);
            `CHK("old", k == 0 ? 8'h00 : CFGS[(k+3)%4], rx)
            wait_idle();
            `CHK("wel clear", 1'b0, write_enable_latch)
            cmd(16, 24'h150000);
            `CHK("config", CFGS[k], rx)
            `CHK("drive", CFGS[k][6:5], view_q.drive)
            m = {CFGS[k][4], CFGS[k][4] | CFGS[k][3], 8'hff};
            `CHK("page", {1'b0, m} + 11'h1, view_q.page_bytes)
            `CHK("erase", CFGS[k][4:3],
                {view_q.erase_quad_page, view_q.erase_dual_page})
            `CHK("scheme", CFGS[k][2], view_q.block_lock_scheme)
            `CHK("pin", CFGS[k][7], view_q.pin_is_reset)
            buf_start = 1'b1;
            tick(1);
            buf_start = 1'b0;
            buf_load = 1'b1;
            tick(1);
            buf_load = 1'b0;
            `CHK("wrap", (10'h2ff & ~m) | (10'h300 & m), buf_addr_q)
        end
    endtask
    task automatic s_status();
        erase_suspended = 1'b1;
        program_suspended = 1'b1;
        write_enable_cmd();
        cmd(24, 24'h017f42);
        wait_idle();
        `CHK("status", 16'hc67c, status_word)
        write_enable_cmd();
        cmd(16, 24'h010000);
        `CHK("busy", 1'b1, write_in_progress)
        wait_idle();
        `CHK("short", 16'h8400, status_word)
        write_enable_cmd();
        cmd(20, 24'h01ffff);
        `CHK("odd status", 16'h8402, status_word)
        cmd(17, 24'h11ffff);
        `CHK("odd config", 1'b0, write_in_progress)
        write_enable_cmd();
        cmd(16, 24'h018000);
        wait_idle();
        write_protect_n = 1'b0;
        write_enable_cmd();
        cmd(16, 24'h010000);
        `CHK("locked", 16'h8482, status_word)
        write_protect_n = 1'b1;
        write_enable_cmd();
        cmd(16, 24'h010000);
        wait_idle();
        `CHK("unlocked", 16'h8400, status_word)
    endtask
    task automatic s_ext();
        write_enable_cmd();
        cmd(16, 24'h56ff00);
        cmd(16, 24'hc80000);
        `CHK("ext", 8'h88, rx)
        `CHK("dummy", 8'h8a, {view_q.dummy_2io, view_q.dummy_4io})
        `CHK("learn", 9'h134, {view_q.learn_enable, view_q.learn_pattern})
        do_reset();
        cmd(16, 24'hc80000);
        `CHK("ext reset", 8'h00, rx)
    endtask

    initial begin
        do_reset();
        s_reset_values();
        s_latch_gate();
        s_config();
        s_status();
        s_ext();
        finish_test();
    end

    // run needs well under 2000 clocks
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            finish_test();
        end
    end
endmodule
